// >>> adc_ctrl_pkg.sv
package adc_ctrl_pkg;

	// clocking of this control block
	localparam int unsigned CLK_PERIOD_NS     = 10;
	// stabilisation lockout after a clock-mode change, in microseconds
	localparam int unsigned LOCKOUT_US        = 150;
	localparam int unsigned LOCKOUT_CYCLES    = (LOCKOUT_US * 1000) / CLK_PERIOD_NS;
	localparam int unsigned LOCK_W            = 16;

	// master clock dividers
	localparam int unsigned EXT_DIV_RATIO     = 8;
	localparam int unsigned MOD_DIV_RATIO     = 2;
	localparam int unsigned DIV_W             = 3;

	// nominal master clock in kHz, per speed mode
	localparam int unsigned FCLK_HS_KHZ       = 25600;
	localparam int unsigned FCLK_LS_KHZ       = 3200;

	// span encodings
	localparam logic [1:0] SPAN_ONE           = 2'h1;
	localparam logic [1:0] SPAN_TWO           = 2'h2;
	// extended range widens by 25 percent: scale in quarters
	localparam logic [2:0] SCALE_STD_QTR      = 3'h4;
	localparam logic [2:0] SCALE_EXT_QTR      = 3'h5;

	// output code limits
	localparam logic [23:0] CODE_POS_FULL     = 24'h7fffff;
	localparam logic [23:0] CODE_NEG_FULL     = 24'h800000;

	// reset values of the configuration state
	localparam logic CLK_SEL_RESET            = 1'b0;

	typedef enum logic [1:0] {
		LOCK_IDLE,
		LOCK_ACTIVE
	} lock_state_t;

endpackage

// >>> clock_divider.sv
`timescale 1ns/1ps

// divides a clock-enable stream by a fixed ratio, producing one tick per RATIO inputs
module clock_divider
	import adc_ctrl_pkg::*;
#(
	parameter int unsigned RATIO = 2
)
(
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic tick_in,
	output logic      tick_out
);

	logic [DIV_W-1:0] count_q;
	logic [DIV_W-1:0] count_d;
	logic             wrap;
	logic             out_d;
	logic             out_q;

	// wrap at the last input tick of each group
	assign wrap    = tick_in && (count_q == DIV_W'(RATIO - 1));
	assign count_d = wrap ? '0 : (tick_in ? count_q + DIV_W'(1) : count_q);
	assign out_d   = wrap;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			count_q <= '0;
			out_q   <= 1'b0;
		end
		else
		begin
			count_q <= count_d;
			out_q   <= out_d;
		end
	end

	assign tick_out = out_q;

endmodule

// >>> adc_range_clock_control.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RQ1: the input span is plus or minus the reference when the span bit is 0 and twice it at 1.
// RQ2: with the high-reference range chosen, the 1x span is applied whatever the span bit says.
// RQ3: extended range widens the span by a quarter, full-scale codes standing at 1.25 k Vref.
// RQ4: the host sets the reference range to match the reference it applies.
// RQ5: where the two reference ranges overlap the host should prefer the low range.
// RQ6: after reset the internal oscillator runs and the clock-source bit reads 0.
// RQ7: the master clock is nominally 25.6 MHz in high speed and 3.2 MHz in low speed.
// RQ8: the internal oscillator follows the speed mode without host action.
// RQ9: with the divide bit at 1 the external clock is divided by eight for low speed.
// RQ10: the modulator clock is the master clock divided by two.
// RQ11: the host runs the external clock before selecting it.
// RQ12: the host keeps the external clock for four cycles after switching back.
// RQ13: after any clock-mode change the start and reset pins are ignored for 150 us.
// RQ14: the host may slow the external clock; conversion timing scales with it.
// RQ15: a saturation flag is latched over a conversion and refreshed at its completion.
// RQ16: start restarts the filter and the reset pin resets the converter.
// RQ17: start or reset edges inside the lockout are dropped, not queued.
module adc_range_clock_control
	import adc_ctrl_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        input_span_select,
	input  wire logic        reference_span_select,
	input  wire logic        extended_range,
	input  wire logic        clk_source_select,
	input  wire logic        clk_divide_select,
	input  wire logic        high_speed_mode,
	input  wire logic        ext_clk_tick,
	input  wire logic        int_osc_hs_tick,
	input  wire logic        int_osc_ls_tick,
	input  wire logic        start_pin,
	input  wire logic        reset_pin,
	input  wire logic        modulator_saturated,
	input  wire logic        conversion_done,
	output logic [1:0]       span_factor,
	output logic [2:0]       span_scale_qtr,
	output logic [23:0]      code_pos_full,
	output logic [23:0]      code_neg_full,
	output logic             clk_source_active,
	output logic             master_clk_tick,
	output logic             modulator_clk_tick,
	output logic [15:0]      nominal_fclk_khz,
	output logic             control_locked,
	output logic             filter_restart,
	output logic             converter_reset,
	output logic             modulator_saturation_flag
);

	////////////////////////////////////////////////////////////////////////////
	// range selection

	logic [1:0]  span_d;
	logic [2:0]  scale_d;

	// RQ1 span from bit
	// RQ2 high reference forces 1x
	assign span_d  = (input_span_select && !reference_span_select) ? SPAN_TWO : SPAN_ONE;
	// RQ3 quarter-step widening
	assign scale_d = extended_range ? SCALE_EXT_QTR : SCALE_STD_QTR;

	logic [1:0]  span_q;
	logic [2:0]  scale_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			span_q  <= SPAN_ONE;
			scale_q <= SCALE_STD_QTR;
		end
		else
		begin
			span_q  <= span_d;
			scale_q <= scale_d;
		end
	end

	assign span_factor    = span_q;
	assign span_scale_qtr = scale_q;
	// RQ3 full-scale codes are fixed; only the analog scale moves
	assign code_pos_full  = CODE_POS_FULL;
	assign code_neg_full  = CODE_NEG_FULL;

	////////////////////////////////////////////////////////////////////////////
	// clock source and dividers

	logic clk_sel_q;
	logic clk_sel_prev_q;
	logic mode_change;

	// RQ6 internal oscillator after reset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			clk_sel_q      <= CLK_SEL_RESET;
			clk_sel_prev_q <= CLK_SEL_RESET;
		end
		else
		begin
			clk_sel_q      <= clk_source_select;
			clk_sel_prev_q <= clk_sel_q;
		end
	end

	assign mode_change       = clk_sel_q != clk_sel_prev_q;
	assign clk_source_active = clk_sel_q;

	logic ext_div8_tick;

	// RQ9 divide external clock by eight
	clock_divider #(
		.RATIO    (EXT_DIV_RATIO)
	) u_ext_div (
		.clk      (clk),
		.rst      (rst),
		.tick_in  (ext_clk_tick),
		.tick_out (ext_div8_tick)
	);

	logic ext_master;
	logic int_master;
	logic master_d;

	// divider bypassed unless requested; stage adds one cycle of latency
	assign ext_master = clk_divide_select ? ext_div8_tick : ext_clk_tick;
	// RQ8 oscillator follows speed mode
	assign int_master = high_speed_mode ? int_osc_hs_tick : int_osc_ls_tick;
	assign master_d   = clk_sel_q ? ext_master : int_master;

	logic master_q;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			master_q <= 1'b0;
		else
			master_q <= master_d;
	end

	assign master_clk_tick = master_q;

	// RQ10 modulator at half the master rate
	clock_divider #(
		.RATIO    (MOD_DIV_RATIO)
	) u_mod_div (
		.clk      (clk),
		.rst      (rst),
		.tick_in  (master_q),
		.tick_out (modulator_clk_tick)
	);

	// RQ7 nominal master frequency report
	assign nominal_fclk_khz = high_speed_mode ? 16'(FCLK_HS_KHZ) : 16'(FCLK_LS_KHZ);

	////////////////////////////////////////////////////////////////////////////
	// control-pin lockout

	lock_state_t       lock_state_q;
	lock_state_t       lock_state_d;
	logic [LOCK_W-1:0] lock_cnt_q;
	logic [LOCK_W-1:0] lock_cnt_d;
	logic              lock_last;

	assign lock_last = lock_cnt_q == LOCK_W'(LOCKOUT_CYCLES - 1);

	// RQ13 150 us window, restarted by every mode change
	always_comb
	begin
		lock_state_d = lock_state_q;
		lock_cnt_d   = lock_cnt_q;
		unique case (lock_state_q)
			LOCK_IDLE:
			begin
				if (mode_change)
				begin
					lock_state_d = LOCK_ACTIVE;
					lock_cnt_d   = '0;
				end
			end
			LOCK_ACTIVE:
			begin
				if (mode_change)
					lock_cnt_d = '0;
				else if (lock_last)
					lock_state_d = LOCK_IDLE;
				else
					lock_cnt_d = lock_cnt_q + LOCK_W'(1);
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			lock_state_q <= LOCK_IDLE;
			lock_cnt_q   <= '0;
		end
		else
		begin
			lock_state_q <= lock_state_d;
			lock_cnt_q   <= lock_cnt_d;
		end
	end

	assign control_locked = lock_state_q == LOCK_ACTIVE;

	// pin edge detection; pins are already synchronous
	logic start_prev_q;
	logic reset_prev_q;
	logic start_rise;
	logic reset_rise;
	logic restart_q;
	logic conv_reset_q;

	assign start_rise = start_pin && !start_prev_q;
	assign reset_rise = reset_pin && !reset_prev_q;

	// RQ16 act on pin assertion
	// RQ17 edges inside the lockout are simply lost
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			start_prev_q <= 1'b0;
			reset_prev_q <= 1'b0;
			restart_q    <= 1'b0;
			conv_reset_q <= 1'b0;
		end
		else
		begin
			start_prev_q <= start_pin;
			reset_prev_q <= reset_pin;
			restart_q    <= start_rise && !control_locked;
			conv_reset_q <= reset_rise && !control_locked;
		end
	end

	assign filter_restart  = restart_q;
	assign converter_reset = conv_reset_q;

	////////////////////////////////////////////////////////////////////////////
	// modulator saturation status

	logic sat_acc_q;
	logic sat_flag_q;

	// RQ15 accumulate over the conversion, publish at its end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sat_acc_q  <= 1'b0;
			sat_flag_q <= 1'b0;
		end
		else if (conversion_done)
		begin
			sat_flag_q <= sat_acc_q || modulator_saturated;
			sat_acc_q  <= 1'b0;
		end
		else if (modulator_saturated)
			sat_acc_q <= 1'b1;
	end

	assign modulator_saturation_flag = sat_flag_q;

endmodule

// >>> clk_source_model.sv
`timescale 1ns/1ps
module clk_source_model
(
	input  wire logic clk,
	input  wire logic rst,
	output logic      ext_clk_tick,
	output logic      int_osc_hs_tick,
	output logic      int_osc_ls_tick
);
	logic [3:0] ph_q;
	// free phase count; these clocks never pause
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			ph_q <= 4'h0;
		else
			ph_q <= ph_q + 4'h1;
	end
	// ext clock, at the high-speed oscillator rate, runs before and after use
	assign ext_clk_tick = ph_q[0];
	assign int_osc_hs_tick = ph_q[0];
	assign int_osc_ls_tick = &ph_q;
endmodule

// >>> range_clock_chk.sv
`timescale 1ns/1ps
module range_clock_chk
	import adc_ctrl_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       input_span_select,
	input wire logic       reference_span_select,
	input wire logic       extended_range,
	input wire logic       start_pin,
	input wire logic       modulator_saturated,
	input wire logic       conversion_done,
	input wire logic [1:0] span_factor,
	input wire logic [2:0] span_scale_qtr,
	input wire logic       master_clk_tick,
	input wire logic       clk_source_active,
	input wire logic       modulator_clk_tick,
	input wire logic       control_locked,
	input wire logic       filter_restart,
	input wire logic       modulator_saturation_flag
);
	logic [15:0] lock_len_q;
	logic        sat_seen_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// lockout run length, restarted by a source change; saturation seen in this conversion
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			lock_len_q <= 16'h0;
			sat_seen_q <= 1'b0;
		end
		else
		begin
			lock_len_q <= (control_locked && !$changed(clk_source_active)) ? lock_len_q + 16'h1
				: 16'h0;
			sat_seen_q <= !conversion_done && (sat_seen_q || modulator_saturated);
		end
	end
	sequence open_rise_s; $rose(start_pin) && !control_locked; endsequence
	sequence shut_rise_s; $rose(start_pin) && control_locked; endsequence
	span_sel_a: assert property (!$past(rst) && !$past(reference_span_select) |->
		span_factor == ($past(input_span_select) ? 2'h2 : 2'h1)) else $error("span wrong");
	span_forced_a: assert property (!$past(rst) && $past(reference_span_select) |->
		span_factor == 2'h1) else $error("span not forced");
	ext_scale_a: assert property (!$past(rst) |->
		span_scale_qtr == ($past(extended_range) ? 3'h5 : 3'h4)) else $error("scale wrong");
	mod_div_a: assert property (modulator_clk_tick |-> $past(master_clk_tick))
		else $error("modulator tick without master tick");
	lock_len_a: assert property ($fell(control_locked) |-> lock_len_q >= LOCKOUT_CYCLES
		&& lock_len_q <= LOCKOUT_CYCLES + 1) else $error("lockout length wrong");
	pin_take_a: assert property (open_rise_s |=> filter_restart ##1 !filter_restart)
		else $error("restart pulse wrong");
	pin_drop_a: assert property (shut_rise_s |=> !filter_restart[*3])
		else $error("restart during lockout");
	sat_flag_a: assert property (conversion_done |=> modulator_saturation_flag ==
		($past(sat_seen_q) || $past(modulator_saturated))) else $error("flag wrong");
endmodule
bind adc_range_clock_control range_clock_chk u_range_clock_chk (.clk, .rst,
	.input_span_select, .reference_span_select, .extended_range, .start_pin,
	.modulator_saturated, .conversion_done, .span_factor, .span_scale_qtr,
	.master_clk_tick, .clk_source_active, .modulator_clk_tick, .control_locked, .filter_restart,
	.modulator_saturation_flag);

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import adc_ctrl_pkg::*;
	logic clk, rst, input_span_select, reference_span_select, extended_range, start_pin;
	logic clk_source_select, clk_divide_select, high_speed_mode, reset_pin, flag_exp;
	logic modulator_saturated, conversion_done, ext_clk_tick, int_osc_hs_tick;
	logic int_osc_ls_tick, clk_source_active, master_clk_tick, modulator_clk_tick;
	logic control_locked, filter_restart, converter_reset, modulator_saturation_flag;
	logic [1:0] span_factor;
	logic [2:0] span_scale_qtr;
	logic [23:0] code_pos_full, code_neg_full;
	logic [15:0] nominal_fclk_khz;
	int failures, num_checks;
	adc_range_clock_control u_adc_range_clock_control (.clk, .rst, .input_span_select,
		.reference_span_select, .extended_range, .clk_source_select, .clk_divide_select,
		.high_speed_mode, .ext_clk_tick, .int_osc_hs_tick, .int_osc_ls_tick, .start_pin,
		.reset_pin, .modulator_saturated, .conversion_done, .span_factor, .span_scale_qtr,
		.code_pos_full, .code_neg_full, .clk_source_active, .master_clk_tick,
		.modulator_clk_tick, .nominal_fclk_khz, .control_locked, .filter_restart,
		.converter_reset, .modulator_saturation_flag);
	clk_source_model u_clk_source_model (.clk, .rst, .ext_clk_tick, .int_osc_hs_tick,
		.int_osc_ls_tick);
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d, mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// bounded wait for the lockout level
	task automatic wait_lock(input logic lvl);
		int n;
		for (n = 0; control_locked !== lvl && n < 20000; n++)
			@(posedge clk);
		if (n == 20000)
		begin
			chk("lockout wait", 1'b0, 1'b1);
			tally_and_finish();
		end
	endtask
	// one rising edge on a control pin, pulse looked for over three cycles
	task automatic pin(input bit rs, input logic exp);
		logic seen;
		seen = 1'b0;
		@(posedge clk);
		start_pin <= !rs;
		reset_pin <= rs;
		repeat (3)
		begin
			@(posedge clk);
			#1;
			seen = seen | (rs ? converter_reset : filter_restart);
		end
		@(posedge clk);
		start_pin <= 1'b0;
		reset_pin <= 1'b0;
		chk(rs ? "converter_reset" : "filter_restart", exp, seen);
	endtask
	// counts are loose by one: window edges cut ticks
	task automatic clk_count(input logic dv, input logic hs, input int em);
		int m, d;
		m = 0;
		d = 0;
		@(posedge clk);
		clk_divide_select <= dv;
		high_speed_mode <= hs;
		repeat (20) @(posedge clk);
		repeat (320)
		begin
			@(posedge clk);
			#1;
			m += master_clk_tick;
			d += modulator_clk_tick;
		end
		chk("master ticks", 1'b1, m >= em - 1 && m <= em + 1);
		chk("modulator ticks", 1'b1, d >= em / 2 - 1 && d <= em / 2 + 1);
		chk("nominal_fclk_khz", hs ? 24'd25600 : 24'd3200, nominal_fclk_khz);
	endtask
	// saturation during one conversion, flag held until the done pulse
	task automatic conv(input logic sat);
		repeat ($urandom_range(1, 8)) @(posedge clk);
		modulator_saturated <= sat;
		@(posedge clk);
		modulator_saturated <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk("flag held", flag_exp, modulator_saturation_flag);
		@(posedge clk);
		conversion_done <= 1'b1;
		@(posedge clk);
		conversion_done <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("flag refreshed", sat, modulator_saturation_flag);
		flag_exp = sat;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		rst = 1'b1;
		flag_exp = 1'b0;
		{input_span_select, reference_span_select, extended_range, clk_source_select} = '0;
		{clk_divide_select, start_pin, reset_pin, modulator_saturated, conversion_done} = '0;
		high_speed_mode = 1'b1;
		void'($urandom(32'h65d6));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk("clk_source_active", 1'b0, clk_source_active);
		chk("span_scale_qtr", 3'h4, span_scale_qtr);
		// all four span combinations first, then random; host range choice
		for (int i = 0; i < 28; i++)
		begin
			@(posedge clk);
			input_span_select <= (i < 4) ? i[0] : 1'($urandom);
			reference_span_select <= (i < 4) ? i[1] : 1'($urandom);
			extended_range <= 1'($urandom);
			repeat (2) @(posedge clk);
			#1;
			chk("span_factor", (input_span_select && !reference_span_select) ? 2'h2 : 2'h1,
				span_factor);
			chk("span_scale_qtr", extended_range ? 3'h5 : 3'h4, span_scale_qtr);
		end
		chk("code_pos_full", 24'h7fffff, code_pos_full);
		chk("code_neg_full", 24'h800000, code_neg_full);
		$display("test spans done");
		pin(1'b0, 1'b1);
		pin(1'b1, 1'b1);
		clk_count(1'b0, 1'b1, 160);
		clk_count(1'b0, 1'b0, 20);
		$display("test internal clock done");
		@(posedge clk);
		clk_source_select <= 1'b1;
		wait_lock(1'b1);
		chk("clk_source_active", 1'b1, clk_source_active);
		pin(1'b0, 1'b0);
		pin(1'b1, 1'b0);
		wait_lock(1'b0);
		repeat (2) @(posedge clk);
		#1;
		chk("queued pulse", 1'b0, filter_restart | converter_reset);
		pin(1'b0, 1'b1);
		clk_count(1'b0, 1'b1, 160);
		clk_count(1'b1, 1'b0, 20);
		@(posedge clk);
		clk_source_select <= 1'b0;
		wait_lock(1'b1);
		// two more changes inside the window; each one restarts the count
		repeat (20) @(posedge clk);
		clk_source_select <= 1'b1;
		repeat (20) @(posedge clk);
		clk_source_select <= 1'b0;
		// without the last restart the window would already have closed here
		repeat (14990) @(posedge clk);
		#1;
		chk("lockout restarted", 1'b1, control_locked);
		wait_lock(1'b0);
		chk("clk_source_active", 1'b0, clk_source_active);
		$display("test clock switch done");
		for (int i = 0; i < 9; i++)
			conv((i < 5) ? 1'(5'b01101 >> i) : 1'($urandom));
		// corner: saturation in the done cycle belongs to that conversion
		@(posedge clk);
		modulator_saturated <= 1'b1;
		conversion_done <= 1'b1;
		@(posedge clk);
		modulator_saturated <= 1'b0;
		conversion_done <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk("flag same cycle", 1'b1, modulator_saturation_flag);
		flag_exp = 1'b1;
		conv(1'b0);
		$display("test saturation done");
		tally_and_finish();
	end
endmodule
